// ==== inc/pwm_fault_pkg.sv ====
// constants, field layout and state record of the pwm fault and dead-time block
// Operation
// - three fault pins are offered, two routable ones and one fixed safety-class pin.
// - an asserted, enabled fault forces both outputs into the safe state (both low).
// - the block owns the safety-class pin throughout reset.
// - reset leaves the safety-class fault enabled, in latched mode and already latched.
// - writes to the fault mode field take effect whatever the safety pin level.
// - a 16-bit read/write duty cycle value, reset to zero, sets the duty cycle.
// - with the independent time base off, the phase value shifts the shared time base.
// - with the independent time base on, the phase value is the local period.
// - a 14-bit primary dead time, reset to zero, feeds the dead-time unit.
// - a 14-bit alternate dead time, reset to zero, feeds the dead-time unit.
// - the two top bits of both dead-time registers read zero and ignore writes.
// - on the local time base with the generator enabled, a match with the trigger compare value raises an adc trigger.
package pwm_fault_pkg;
    // ========================================
    // register offsets
    localparam logic [7:0] DUTY_OFS       = 8'h00;
    localparam logic [7:0] PHASE_OFS      = 8'h04;
    localparam logic [7:0] DEAD_OFS       = 8'h08;
    localparam logic [7:0] ALT_DEAD_OFS   = 8'h0C;
    localparam logic [7:0] TRIG_OFS       = 8'h10;
    localparam logic [7:0] GEN_CTRL_OFS   = 8'h14;
    localparam logic [7:0] FAULT_CTRL_OFS = 8'h18;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h1C;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h20;
    localparam logic [7:0] LIVE_OFS       = 8'h24;
    // ========================================
    // field positions
    localparam int GEN_ENABLE_BIT     = 0;
    localparam int ITB_BIT            = 1;
    localparam int PMOD_LSB           = 2;
    localparam int ALT_SEL_BIT        = 4;
    localparam int FMODE_LSB          = 0;
    localparam int REMAP1_EN_BIT      = 2;
    localparam int REMAP2_EN_BIT      = 3;
    localparam int FAULT_CLEAR_BIT    = 4;
    localparam int SAFETY_RELEASE_BIT = 5;
    localparam int IRQ_FAULT_BIT      = 0;
    localparam int IRQ_TRIG_BIT       = 1;
    localparam int IRQ_PERIOD_BIT     = 2;
    localparam int LIVE_LATCH_BIT     = 0;
    localparam int LIVE_PINS_LSB      = 1;
    localparam int LIVE_SAFE_BIT      = 4;
    localparam int DEAD_W             = 14;
    localparam int IRQ_W              = 3;
    // ========================================
    // encodings and reset values
    localparam logic [1:0] FMODE_LATCHED = 2'h0;
    localparam logic [1:0] FMODE_CYCLE   = 2'h1;
    localparam logic [1:0] FMODE_OFF     = 2'h3;
    localparam logic [1:0] PMOD_COMP     = 2'h0;
    localparam logic [1:0] PMOD_RED      = 2'h1;
    localparam logic [1:0] PMOD_PP       = 2'h2;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    localparam logic [15:0] REG16_RST    = 16'h0000;
    localparam logic [13:0] DEAD_RST     = 14'h0000;
    localparam logic [1:0] FMODE_RST     = FMODE_LATCHED;
    localparam logic       LATCH_RST     = 1'h1;
    // ========================================
    // state record
    typedef struct packed {
        logic              aw_got;
        logic [7:0]        aw_addr;
        logic              w_got;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [15:0]       duty;
        logic [15:0]       phase;
        logic [13:0]       dead;
        logic [13:0]       alt_dead;
        logic [15:0]       trig;
        logic              gen_en;
        logic              independent_time_base_select;
        logic [1:0]        pmod;
        logic              alt_sel;
        logic [1:0]        fmode;
        logic              remap1_en;
        logic              remap2_en;
        logic              safety_release;
        logic [IRQ_W-1:0]  irq_status;
        logic [IRQ_W-1:0]  irq_mask;
        logic              fault_latched;
        logic [2:0]        sync1;
        logic [2:0]        sync2;
        logic [15:0]       count;
        logic              pp_phase;
        logic              raw_prev;
        logic [13:0]       dt_count;
        logic              high_out;
        logic              low_out;
        logic              adc_trig;
        logic              irq;
        logic              pin_owned;
    } state_s;
endpackage

// ==== verilog/pwm_fault_deadtime_regs.sv ====
// pwm generator with fault handling, dead time and axi4-lite registers
module pwm_fault_deadtime_regs (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    input  wire logic [15:0] master_period,
    input  wire logic        master_sync,
    input  wire logic        safety_class_fault_input,
    input  wire logic        remappable_fault_input_one,
    input  wire logic        remappable_fault_input_two,
    output logic             high_side_output,
    output logic             low_side_output,
    output logic             adc_trigger,
    output logic             irq,
    output logic             safety_pin_owned
);
    // ========================================
    // helpers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'h0};
        is_mapped = (w == pwm_fault_pkg::DUTY_OFS) || (w == pwm_fault_pkg::PHASE_OFS) ||
                    (w == pwm_fault_pkg::DEAD_OFS) || (w == pwm_fault_pkg::ALT_DEAD_OFS) ||
                    (w == pwm_fault_pkg::TRIG_OFS) || (w == pwm_fault_pkg::GEN_CTRL_OFS) ||
                    (w == pwm_fault_pkg::FAULT_CTRL_OFS) ||
                    (w == pwm_fault_pkg::IRQ_STATUS_OFS) ||
                    (w == pwm_fault_pkg::IRQ_MASK_OFS) || (w == pwm_fault_pkg::LIVE_OFS);
    endfunction

    function automatic logic [31:0] read_reg(input pwm_fault_pkg::state_s s,
                                             input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case ({a[7:2], 2'h0})
            pwm_fault_pkg::DUTY_OFS:       v[15:0] = s.duty;
            pwm_fault_pkg::PHASE_OFS:      v[15:0] = s.phase;
            // upper dead-time bits read zero
            pwm_fault_pkg::DEAD_OFS:       v[13:0] = s.dead;
            pwm_fault_pkg::ALT_DEAD_OFS:   v[13:0] = s.alt_dead;
            pwm_fault_pkg::TRIG_OFS:       v[15:0] = s.trig;
            pwm_fault_pkg::GEN_CTRL_OFS: begin
                v[pwm_fault_pkg::GEN_ENABLE_BIT]     = s.gen_en;
                v[pwm_fault_pkg::ITB_BIT]            = s.independent_time_base_select;
                v[pwm_fault_pkg::PMOD_LSB +: 2]      = s.pmod;
                v[pwm_fault_pkg::ALT_SEL_BIT]        = s.alt_sel;
            end
            pwm_fault_pkg::FAULT_CTRL_OFS: begin
                v[pwm_fault_pkg::FMODE_LSB +: 2]     = s.fmode;
                v[pwm_fault_pkg::REMAP1_EN_BIT]      = s.remap1_en;
                v[pwm_fault_pkg::REMAP2_EN_BIT]      = s.remap2_en;
                v[pwm_fault_pkg::SAFETY_RELEASE_BIT] = s.safety_release;
            end
            pwm_fault_pkg::IRQ_STATUS_OFS: v[pwm_fault_pkg::IRQ_W-1:0] = s.irq_status;
            pwm_fault_pkg::IRQ_MASK_OFS:   v[pwm_fault_pkg::IRQ_W-1:0] = s.irq_mask;
            pwm_fault_pkg::LIVE_OFS: begin
                v[pwm_fault_pkg::LIVE_LATCH_BIT]     = s.fault_latched;
                v[pwm_fault_pkg::LIVE_PINS_LSB +: 3] = s.sync2;
                v[pwm_fault_pkg::LIVE_SAFE_BIT]      = ~s.high_out & ~s.low_out;
            end
            default:                       v = 32'h0000_0000;
        endcase
        read_reg = v;
    endfunction

    pwm_fault_pkg::state_s st_r;
    pwm_fault_pkg::state_s st_nxt;

    logic        fault_in;
    logic        wr_fire;
    logic        clear_req;
    logic        raw;
    logic [15:0] period;
    logic [13:0] sel_dead;

    // ========================================
    // fault detect
    // three fault pins
    assign fault_in  = (st_r.fmode != pwm_fault_pkg::FMODE_OFF) &&
                       (st_r.sync2[0] || (st_r.sync2[1] && st_r.remap1_en) ||
                        (st_r.sync2[2] && st_r.remap2_en));
    assign wr_fire   = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign clear_req = wr_fire && st_r.wstrb[0] &&
                       ({st_r.aw_addr[7:2], 2'h0} == pwm_fault_pkg::FAULT_CTRL_OFS) &&
                       st_r.wdata[pwm_fault_pkg::FAULT_CLEAR_BIT];
    assign period    = st_r.independent_time_base_select ? st_r.phase : master_period;
    assign raw       = st_r.count < st_r.duty;
    assign sel_dead  = st_r.alt_sel ? st_r.alt_dead : st_r.dead;

    // ========================================
    // next state
    always_comb begin
        logic [7:0] wa;
        logic       dt_zero;
        logic       h;
        logic       l;
        logic [pwm_fault_pkg::IRQ_W-1:0] set_ev;
        logic [15:0] m16;
        wa      = {st_r.aw_addr[7:2], 2'h0};
        m16     = 16'h0000;
        dt_zero = 1'b0;
        h       = 1'b0;
        l       = 1'b0;
        set_ev  = '0;
        st_nxt  = st_r;
        st_nxt.sync1 = {remappable_fault_input_two, remappable_fault_input_one,
                        safety_class_fault_input};
        st_nxt.sync2 = st_r.sync1;
        // write channel
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (awvalid && st_r.awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = awaddr[7:0];
        end
        if (wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        if (wr_fire) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = is_mapped(st_r.aw_addr) ? pwm_fault_pkg::RESP_OKAY
                                                    : pwm_fault_pkg::RESP_SLVERR;
            unique case (wa)
                pwm_fault_pkg::DUTY_OFS:
                    st_nxt.duty = merge16(st_r.duty, st_r.wdata, st_r.wstrb);
                pwm_fault_pkg::PHASE_OFS:
                    st_nxt.phase = merge16(st_r.phase, st_r.wdata, st_r.wstrb);
                pwm_fault_pkg::DEAD_OFS: begin
                    m16         = merge16({2'h0, st_r.dead}, st_r.wdata, st_r.wstrb);
                    st_nxt.dead = m16[pwm_fault_pkg::DEAD_W-1:0];
                end
                pwm_fault_pkg::ALT_DEAD_OFS: begin
                    m16             = merge16({2'h0, st_r.alt_dead}, st_r.wdata, st_r.wstrb);
                    st_nxt.alt_dead = m16[pwm_fault_pkg::DEAD_W-1:0];
                end
                pwm_fault_pkg::TRIG_OFS:
                    st_nxt.trig = merge16(st_r.trig, st_r.wdata, st_r.wstrb);
                pwm_fault_pkg::GEN_CTRL_OFS: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.gen_en  = st_r.wdata[pwm_fault_pkg::GEN_ENABLE_BIT];
                        st_nxt.independent_time_base_select     = st_r.wdata[pwm_fault_pkg::ITB_BIT];
                        st_nxt.pmod    = st_r.wdata[pwm_fault_pkg::PMOD_LSB +: 2];
                        st_nxt.alt_sel = st_r.wdata[pwm_fault_pkg::ALT_SEL_BIT];
                    end
                end
                pwm_fault_pkg::FAULT_CTRL_OFS: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.fmode          = st_r.wdata[pwm_fault_pkg::FMODE_LSB +: 2];
                        st_nxt.remap1_en      = st_r.wdata[pwm_fault_pkg::REMAP1_EN_BIT];
                        st_nxt.remap2_en      = st_r.wdata[pwm_fault_pkg::REMAP2_EN_BIT];
                        st_nxt.safety_release = st_r.wdata[pwm_fault_pkg::SAFETY_RELEASE_BIT];
                    end
                end
                pwm_fault_pkg::IRQ_STATUS_OFS: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.irq_status = st_r.irq_status &
                                            ~st_r.wdata[pwm_fault_pkg::IRQ_W-1:0];
                    end
                end
                pwm_fault_pkg::IRQ_MASK_OFS: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.irq_mask = st_r.wdata[pwm_fault_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
        // read channel
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = read_reg(st_r, araddr[7:0]);
            st_nxt.rresp  = is_mapped(araddr[7:0]) ? pwm_fault_pkg::RESP_OKAY
                                                   : pwm_fault_pkg::RESP_SLVERR;
        end
        st_nxt.arready = !st_nxt.rvalid;
        // clear only while input idle, set wins
        if (clear_req && !fault_in) begin
            st_nxt.fault_latched = 1'b0;
        end
        if (fault_in && (st_r.fmode != pwm_fault_pkg::FMODE_CYCLE)) begin
            st_nxt.fault_latched = 1'b1;
        end
        if (!st_r.independent_time_base_select && master_sync) begin
            st_nxt.count = st_r.phase;
        end else if (st_r.count >= period) begin
            st_nxt.count    = 16'h0000;
            st_nxt.pp_phase = !st_r.pp_phase;
            set_ev[pwm_fault_pkg::IRQ_PERIOD_BIT] = 1'b1;
        end else begin
            st_nxt.count = st_r.count + 16'h0001;
        end
        st_nxt.adc_trig = st_r.gen_en && st_r.independent_time_base_select && (st_r.count == st_r.trig);
        set_ev[pwm_fault_pkg::IRQ_TRIG_BIT]  = st_nxt.adc_trig;
        set_ev[pwm_fault_pkg::IRQ_FAULT_BIT] = fault_in;
        st_nxt.raw_prev = raw;
        if (raw != st_r.raw_prev) begin
            st_nxt.dt_count = sel_dead;
        end else if (st_r.dt_count != 14'h0000) begin
            st_nxt.dt_count = st_r.dt_count - 14'h0001;
        end
        dt_zero = (st_nxt.dt_count == 14'h0000);
        unique case (st_r.pmod)
            pwm_fault_pkg::PMOD_COMP: begin
                h = raw && dt_zero;
                l = !raw && dt_zero;
            end
            pwm_fault_pkg::PMOD_PP: begin
                h = raw && st_r.pp_phase;
                l = raw && !st_r.pp_phase;
            end
            default: begin
                h = raw;
                l = raw;
            end
        endcase
        if (st_nxt.fault_latched || (fault_in && st_r.fmode == pwm_fault_pkg::FMODE_CYCLE) ||
            !st_r.gen_en) begin
            h = 1'b0;
            l = 1'b0;
        end
        st_nxt.high_out = h;
        st_nxt.low_out  = l;
        st_nxt.irq_status = st_nxt.irq_status | set_ev;
        st_nxt.irq        = |(st_nxt.irq_status & st_nxt.irq_mask);
        st_nxt.pin_owned  = !st_nxt.safety_release;
    end

    // ========================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r                <= '0;
            st_r.duty           <= pwm_fault_pkg::REG16_RST;
            st_r.phase          <= pwm_fault_pkg::REG16_RST;
            st_r.trig           <= pwm_fault_pkg::REG16_RST;
            st_r.dead           <= pwm_fault_pkg::DEAD_RST;
            st_r.alt_dead       <= pwm_fault_pkg::DEAD_RST;
            st_r.fmode          <= pwm_fault_pkg::FMODE_RST;
            st_r.fault_latched  <= pwm_fault_pkg::LATCH_RST;
            st_r.pin_owned      <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign awready          = st_r.awready;
    assign wready           = st_r.wready;
    assign bvalid           = st_r.bvalid;
    assign bresp            = st_r.bresp;
    assign arready          = st_r.arready;
    assign rvalid           = st_r.rvalid;
    assign rdata            = st_r.rdata;
    assign rresp            = st_r.rresp;
    assign high_side_output = st_r.high_out;
    assign low_side_output  = st_r.low_out;
    assign adc_trigger      = st_r.adc_trig;
    assign irq              = st_r.irq;
    assign safety_pin_owned = st_r.pin_owned;

    // ========================================
    // checks
    a_reset_latched: assert property (@(posedge aclk) !aresetn |=>
        st_r.fault_latched && st_r.fmode == pwm_fault_pkg::FMODE_LATCHED)
        else $error("fault not latched after reset");
    a_reset_owned: assert property (@(posedge aclk) !aresetn |=> safety_pin_owned)
        else $error("safety pin not owned in reset");
    a_latch_safe: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.fault_latched |-> !high_side_output && !low_side_output)
        else $error("outputs active while fault latched");
    a_latch_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.fault_latched && (!clear_req || fault_in) |=> st_r.fault_latched)
        else $error("latched fault dropped without valid clear");
    a_mode_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.wstrb[0] &&
        {st_r.aw_addr[7:2], 2'h0} == pwm_fault_pkg::FAULT_CTRL_OFS
        |=> st_r.fmode == $past(st_r.wdata[1:0]))
        else $error("fault mode write lost");
    a_duty_store: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.wstrb == 4'hF && {st_r.aw_addr[7:2], 2'h0} == pwm_fault_pkg::DUTY_OFS
        |=> st_r.duty == $past(st_r.wdata[15:0]))
        else $error("duty write lost");
    a_dead_upper: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && {araddr[7:2], 2'h0} == pwm_fault_pkg::DEAD_OFS
        |=> rvalid && rdata[31:14] == 18'h00000)
        else $error("dead time upper bits not zero");
    a_phase_load: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_r.independent_time_base_select && master_sync |=> st_r.count == $past(st_r.phase))
        else $error("phase not loaded on sync");
    a_local_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.independent_time_base_select && st_r.count >= st_r.phase |=> st_r.count == 16'h0000)
        else $error("local period wrap missed");
    a_trig_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.gen_en && st_r.independent_time_base_select && st_r.count == st_r.trig |=> adc_trigger)
        else $error("adc trigger missed");
    a_dead_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.pmod == pwm_fault_pkg::PMOD_COMP && raw != st_r.raw_prev && sel_dead != 14'h0000
        |=> !high_side_output && !low_side_output)
        else $error("no dead-time gap");

endmodule // pwm_fault_deadtime_regs

// ==== bench/fault_sense_model.sv ====
// power stage and fault sensing model
module fault_sense_model (
    input  wire logic       aclk,
    input  wire logic [2:0] trip,
    input  wire logic       high_side_output,
    input  wire logic       low_side_output,
    output logic [2:0]      fault_pins,
    output int              shoot_through
);
    timeunit 1ns;
    timeprecision 1ps;
    assign fault_pins = trip;
    initial shoot_through = 0;
    always @(posedge aclk) begin
        if (high_side_output && low_side_output) shoot_through <= shoot_through + 1;
    end
endmodule // fault_sense_model

// ==== bench/tb.sv ====
// bench of the pwm fault and dead-time block
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_s;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, master_sync;
    logic [31:0] awaddr, wdata, araddr, rdata, rdv;
    logic [3:0]  wstrb;
    logic [2:0]  awprot, arprot, trip, pins;
    logic [1:0]  bresp, rresp, resp;
    logic [15:0] master_period;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        high_side_output, low_side_output, adc_trigger, irq, safety_pin_owned;
    int          mismatches, n_tests, shoot, gap, hi;
    row_s        rows [6] = '{
        '{pwm_fault_pkg::DUTY_OFS, 32'h0000FFFF, 32'h0000FFFF, 2'h0},
        '{pwm_fault_pkg::PHASE_OFS, 32'h00001234, 32'h00001234, 2'h0},
        '{pwm_fault_pkg::DEAD_OFS, 32'h0000FFFF, 32'h00003FFF, 2'h0},
        '{pwm_fault_pkg::ALT_DEAD_OFS, 32'h0000C001, 32'h00000001, 2'h0},
        '{pwm_fault_pkg::TRIG_OFS, 32'h0000ABCD, 32'h0000ABCD, 2'h0},
        '{8'h40, 32'h0000FFFF, 32'h00000000, pwm_fault_pkg::RESP_SLVERR}};
    pwm_fault_deadtime_regs DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .master_period, .master_sync,
        .safety_class_fault_input(pins[0]), .remappable_fault_input_one(pins[1]),
        .remappable_fault_input_two(pins[2]), .high_side_output, .low_side_output,
        .adc_trigger, .irq, .safety_pin_owned);
    fault_sense_model far_side (.aclk, .trip, .high_side_output, .low_side_output,
        .fault_pins(pins), .shoot_through(shoot));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= {24'h000000, a};
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rdv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("mismatches %0d, n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        wrap_up;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, master_sync} = 7'h00;
        {awaddr, wdata, araddr, wstrb, awprot, arprot, trip} = '0;
        master_period = 16'h0010;
        repeat (8) @(posedge aclk);
        `CHK(safety_pin_owned, 1'b1)
        aresetn <= 1'b1;
        rd(pwm_fault_pkg::LIVE_OFS);
        `CHK(rdv[4:0], 5'h11)
        foreach (rows[i]) begin
            rd(rows[i].a);
            `CHK(rdv, 32'h00000000)
            wr(rows[i].a, rows[i].d);
            `CHK(resp, rows[i].r)
            rd(rows[i].a);
            `CHK({rdv, resp}, {rows[i].e, rows[i].r})
        end
        trip <= 3'h1;
        wr(pwm_fault_pkg::FAULT_CTRL_OFS, 32'h00000001);
        rd(pwm_fault_pkg::FAULT_CTRL_OFS);
        `CHK(rdv[1:0], pwm_fault_pkg::FMODE_CYCLE)
        wr(pwm_fault_pkg::FAULT_CTRL_OFS, 32'h00000010);
        rd(pwm_fault_pkg::LIVE_OFS);
        `CHK(rdv[0], 1'b1)
        trip <= 3'h0;
        repeat (4) @(posedge aclk);
        wr(pwm_fault_pkg::FAULT_CTRL_OFS, 32'h00000010);
        rd(pwm_fault_pkg::LIVE_OFS);
        `CHK(rdv[0], 1'b0)
        wr(pwm_fault_pkg::DEAD_OFS, 32'h00000003);
        wr(pwm_fault_pkg::DUTY_OFS, 32'h00000008);
        wr(pwm_fault_pkg::IRQ_MASK_OFS, 32'h00000001);
        wr(pwm_fault_pkg::GEN_CTRL_OFS, 32'h00000001);
        repeat (60) @(posedge aclk);
        gap = 0;
        hi = 0;
        repeat (17) @(posedge aclk) begin
            gap += low_side_output;
            hi += high_side_output;
        end
        `CHK(shoot, 0)
        `CHK({hi, gap}, {32'h5, 32'h6})
        trip <= 3'h1;
        repeat (5) @(posedge aclk);
        `CHK({high_side_output, low_side_output, irq}, 3'h1)
        trip <= 3'h0;
        gap = 0;
        repeat (40) @(posedge aclk) gap += high_side_output | low_side_output;
        `CHK(gap, 0)
        wr(pwm_fault_pkg::IRQ_STATUS_OFS, 32'h00000001);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        wr(pwm_fault_pkg::FAULT_CTRL_OFS, 32'h00000010);
        wr(pwm_fault_pkg::PHASE_OFS, 32'h00000009);
        wr(pwm_fault_pkg::TRIG_OFS, 32'h00000003);
        wr(pwm_fault_pkg::GEN_CTRL_OFS, 32'h00000003);
        while (adc_trigger !== 1'b1) @(posedge aclk);
        gap = 0;
        do begin
            @(posedge aclk);
            gap++;
        end while (adc_trigger !== 1'b1);
        `CHK(gap, 10)
        wr(pwm_fault_pkg::GEN_CTRL_OFS, 32'h00000001);
        while (low_side_output !== 1'b1) @(posedge aclk);
        master_sync <= 1'b1;
        @(posedge aclk);
        master_sync <= 1'b0;
        gap = 0;
        do begin
            @(posedge aclk);
            gap++;
        end while (high_side_output !== 1'b1);
        `CHK(gap, 13)
        wr(pwm_fault_pkg::FAULT_CTRL_OFS, 32'h00000004);
        trip <= 3'h2;
        repeat (5) @(posedge aclk);
        rd(pwm_fault_pkg::LIVE_OFS);
        `CHK(rdv[4:0], 5'h15)
        wr(pwm_fault_pkg::FAULT_CTRL_OFS, 32'h00000020);
        `CHK(safety_pin_owned, 1'b0)
        wrap_up;
    end
endmodule // tb
